/* hdl/otg_mon_pkg.sv */
// constants shared by the bus-monitor and charger-control design files
package otg_mon_pkg;
  // clock period of sys_clk in ns
  localparam int          CLK_PERIOD_NS    = 100;
  // channel count and channel positions in the comparator vectors
  localparam int          CH_N             = 4;
  localparam int          CH_BV            = 0;
  localparam int          CH_SV            = 1;
  localparam int          CH_SE            = 2;
  localparam int          CH_VD            = 3;
  // field widths
  localparam int          LS_W             = 2;
  localparam int          LVL_W            = 2;
  // line state code in which data-voltage detect may assert
  localparam logic [1:0]  LS_SE0           = 2'h0;
  // regulator level used outside serial mode
  localparam logic [1:0]  REG_LEVEL_NORMAL = 2'h0;
  // external bus-valid indicator pin is strapped high
  localparam logic        EXT_IND_LEVEL    = 1'h1;
  // values after reset
  localparam logic        RST_OFF          = 1'h0;
  localparam logic [1:0]  RST_LS           = 2'h0;
  // only the session valid comparator keeps running with both enables clear
  localparam logic [3:0]  KEEP_ALIVE_MASK  = 4'h2;
endpackage

/* hdl/cmp_channel.sv */
// one comparator channel: enable gating, status, change and interrupt events
module cmp_channel
  import otg_mon_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // comparator and enables
  input  wire logic raw,
  input  wire logic rise_en,
  input  wire logic fall_en,
  input  wire logic keep_alive,
  // results
  output logic      sts_q,
  output logic      change_q,
  output logic      irq_q
);
  // comparator is powered while any enable is set, or when it must stay alive
  wire logic active = rise_en | fall_en | keep_alive;
  // a disabled comparator reads zero
  wire logic cur    = active & raw;
  // edges against the last reported status
  wire logic rise   = cur & ~sts_q;
  wire logic fall   = ~cur & sts_q;

  // status, change and interrupt flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q    <= RST_OFF;
      change_q <= RST_OFF;
      irq_q    <= RST_OFF;
    end else begin
      sts_q    <= cur;
      change_q <= rise | fall;
      irq_q    <= (rise & rise_en) | (fall & fall_en);
    end
  end
endmodule

/* hdl/ext_ind_decode.sv */
// bus-valid source selection for the status command encoding
module ext_ind_decode
  import otg_mon_pkg::*;
(
  // selection controls
  input  wire logic use_ext,
  input  wire logic pass_thru,
  input  wire logic complement,
  // internal comparator status
  input  wire logic internal_valid,
  // encoded value
  output logic      bus_valid_enc
);
  // pass-through uses the strapped indicator, possibly inverted
  wire logic thru_val = EXT_IND_LEVEL ^ complement;
  // without pass-through the comparator is qualified, or forced low
  wire logic qual_val = complement ? 1'h0 : internal_valid;
  // external logic off selects the comparator directly
  assign bus_valid_enc = use_ext ? (pass_thru ? thru_val : qual_val) : internal_valid;
endmodule

/* hdl/otg_vbus_monitor_control.sv */
// power-bus monitor, pulsing, supply switch and charger-detect control
// Summary of operation
// - comparator outputs readable as status bits
// - session end reads 1 below threshold
// - session end disabled reads 0
// - status command on every session valid change
// - session valid enables gate interrupts only
// - bus valid disabled reads 0
// - external logic off uses internal comparator
// - external indicator decode table
// - external indicator logic off after reset
// - discharge pull-down follows control bit
// - charge pull-up follows control bit
// - supply switch is OR of drive bits
// - drive bits cleared at reset
// - serial mode sets level, hides line state
// - data voltage detect only in SE0
// - data voltage detect interrupts in all modes
// - charger detection works while suspended
// - weak pull-ups off while chip reset low
module otg_vbus_monitor_control (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          chip_reset_n,
  // analog comparator outputs
  input  wire logic                          bus_valid_cmp,
  input  wire logic                          session_valid_cmp,
  input  wire logic                          session_end_cmp,
  input  wire logic                          data_voltage_detect,
  input  wire logic [otg_mon_pkg::LS_W-1:0]  line_state,
  // interrupt enables, one bit per channel
  input  wire logic [otg_mon_pkg::CH_N-1:0]  int_rise_en,
  input  wire logic [otg_mon_pkg::CH_N-1:0]  int_fall_en,
  // external indicator settings
  input  wire logic                          use_ext_valid_ind,
  input  wire logic                          ind_pass_thru,
  input  wire logic                          ind_complement,
  // otg control bits
  input  wire logic                          power_rail_discharge,
  input  wire logic                          power_rail_charge,
  input  wire logic                          supply_drive_req,
  input  wire logic                          ext_supply_drive_req,
  // mode and power management
  input  wire logic                          serial_mode,
  input  wire logic [otg_mon_pkg::LVL_W-1:0] serial_mode_reg_level,
  input  wire logic                          suspend_n,
  // charger detection controls
  input  wire logic                          data_volt_source_en,
  input  wire logic                          data_current_sink_en,
  input  wire logic                          contact_detect_en,
  input  wire logic                          host_charger_en,
  input  wire logic                          plus_line_pulldown,
  input  wire logic                          minus_line_pulldown,
  input  wire logic                          plus_weak_pullup_req,
  input  wire logic                          minus_weak_pullup_req,
  // interrupt status bits
  output logic                               bus_valid_sts,
  output logic                               session_valid_sts,
  output logic                               session_end_sts,
  output logic                               data_voltage_detect_sts,
  // status command towards the link
  output logic                               rx_cmd_req_q,
  output logic                               rx_bus_valid_q,
  output logic                               rx_sess_valid_q,
  output logic                               rx_sess_end_q,
  // interrupt event towards the link
  output logic                               int_event_q,
  output logic [otg_mon_pkg::CH_N-1:0]       int_source_q,
  // analog controls
  output logic                               discharge_en_q,
  output logic                               charge_en_q,
  output logic                               supply_switch_en,
  output logic [otg_mon_pkg::LVL_W-1:0]      reg_level_q,
  output logic [otg_mon_pkg::LS_W-1:0]       pin_line_state_q,
  output logic                               line_state_shown_q,
  output logic                               volt_source_on_q,
  output logic                               current_sink_on_q,
  output logic                               contact_detect_on_q,
  output logic                               host_charger_on_q,
  output logic                               plus_pulldown_on_q,
  output logic                               minus_pulldown_on_q,
  output logic                               plus_weak_pullup_q,
  output logic                               minus_weak_pullup_q
);
  import otg_mon_pkg::*;

  // raw comparator vector, one entry per channel
  wire logic [CH_N-1:0] raw_v;
  // registered per-channel status, change and interrupt events
  wire logic [CH_N-1:0] sts_v;
  wire logic [CH_N-1:0] chg_v;
  wire logic [CH_N-1:0] irq_v;
  // external logic enable; starts off
  logic                 ext_sel_q;
  // decoded bus-valid value for the command encoding
  wire logic            bus_valid_enc;
  // next command field values
  wire logic [2:0]      rx_fields_d;
  wire logic [2:0]      rx_fields_q;
  // supply switch enable register
  logic                 supply_switch_q;
  // data voltage detect qualified by line state
  wire logic            vdat_qual;

  // detect only while both line-state bits are low
  // line state qualification
  assign vdat_qual = data_voltage_detect & (line_state == LS_SE0);

  // gather comparators into the channel vector
  assign raw_v[CH_BV] = bus_valid_cmp;
  assign raw_v[CH_SV] = session_valid_cmp;
  assign raw_v[CH_SE] = session_end_cmp;
  assign raw_v[CH_VD] = vdat_qual;

  // one channel per comparator; session valid is never powered down
  // edge interrupts per channel
  genvar ch;
  generate
    for (ch = 0; ch < CH_N; ch = ch + 1) begin : g_ch
      cmp_channel u_ch (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .raw        (raw_v[ch]),
        .rise_en    (int_rise_en[ch]),
        .fall_en    (int_fall_en[ch]),
        .keep_alive (KEEP_ALIVE_MASK[ch]),
        .sts_q      (sts_v[ch]),
        .change_q   (chg_v[ch]),
        .irq_q      (irq_v[ch])
      );
    end
  endgenerate

  // status bits come from the channel flops
  // comparator status readable
  assign bus_valid_sts           = sts_v[CH_BV];
  assign session_valid_sts       = sts_v[CH_SV];
  assign session_end_sts         = sts_v[CH_SE];
  assign data_voltage_detect_sts = sts_v[CH_VD];

  // external indicator decode
  // internal source by default
  ext_ind_decode u_dec (
    .use_ext        (ext_sel_q),
    .pass_thru      (ind_pass_thru),
    .complement     (ind_complement),
    .internal_valid (sts_v[CH_BV]),
    .bus_valid_enc  (bus_valid_enc)
  );

  // command fields: bus valid, session valid, session end
  assign rx_fields_d = {bus_valid_enc, sts_v[CH_SV], sts_v[CH_SE]};
  assign rx_fields_q = {rx_bus_valid_q, rx_sess_valid_q, rx_sess_end_q};

  // external selection follows the link setting, but is off after reset
  // selection off at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sel_q <= RST_OFF;
    end else begin
      ext_sel_q <= use_ext_valid_ind;
    end
  end

  // status command: a one-cycle request whenever any field changes
  // command on session valid change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cmd_req_q    <= RST_OFF;
      rx_bus_valid_q  <= RST_OFF;
      rx_sess_valid_q <= RST_OFF;
      rx_sess_end_q   <= RST_OFF;
    end else begin
      rx_cmd_req_q    <= (rx_fields_d != rx_fields_q);
      rx_bus_valid_q  <= rx_fields_d[2];
      rx_sess_valid_q <= rx_fields_d[1];
      rx_sess_end_q   <= rx_fields_d[0];
    end
  end

  // interrupt events; not gated by suspend so they work in low power too
  // interrupts in all modes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_event_q  <= RST_OFF;
      int_source_q <= '0;
    end else begin
      int_event_q  <= |irq_v;
      int_source_q <= irq_v;
    end
  end

  // pulsing resistors follow their control bits
  // discharge pull-down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      discharge_en_q <= RST_OFF;
      charge_en_q    <= RST_OFF;
    end else begin
      discharge_en_q <= power_rail_discharge;
      charge_en_q    <= power_rail_charge;
    end
  end

  // supply switch: either drive bit asserts it, both clear at reset
  // OR of drive bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_switch_q <= RST_OFF;
    end else begin
      supply_switch_q <= supply_drive_req | ext_supply_drive_req;
    end
  end
  assign supply_switch_en = supply_switch_q;

  // serial mode: regulator level switches and line state leaves the pins
  // serial mode effects
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_level_q        <= REG_LEVEL_NORMAL;
      pin_line_state_q   <= RST_LS;
      line_state_shown_q <= RST_OFF;
    end else begin
      reg_level_q        <= serial_mode ? serial_mode_reg_level : REG_LEVEL_NORMAL;
      pin_line_state_q   <= serial_mode ? RST_LS : line_state;
      line_state_shown_q <= ~serial_mode;
    end
  end

  // charger controls pass straight through; suspend_n is deliberately
  // ignored so detection keeps working in low power mode. the link owns
  // the mode combinations, this block does not police them.
  // active while suspended
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_source_on_q    <= RST_OFF;
      current_sink_on_q   <= RST_OFF;
      contact_detect_on_q <= RST_OFF;
      host_charger_on_q   <= RST_OFF;
      plus_pulldown_on_q  <= RST_OFF;
      minus_pulldown_on_q <= RST_OFF;
    end else begin
      volt_source_on_q    <= data_volt_source_en;
      current_sink_on_q   <= data_current_sink_en;
      contact_detect_on_q <= contact_detect_en;
      host_charger_on_q   <= host_charger_en;
      plus_pulldown_on_q  <= plus_line_pulldown;
      minus_pulldown_on_q <= minus_line_pulldown;
    end
  end

  // weak pull-ups are forced off while the chip reset pin is low
  // pull-ups off in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      plus_weak_pullup_q  <= RST_OFF;
      minus_weak_pullup_q <= RST_OFF;
    end else begin
      plus_weak_pullup_q  <= chip_reset_n & plus_weak_pullup_req;
      minus_weak_pullup_q <= chip_reset_n & minus_weak_pullup_req;
    end
  end

  // checks share the one clock and reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_status_follows_cmp: assert property (
    (int_rise_en[CH_SV] | int_fall_en[CH_SV]) |=> (session_valid_sts == $past(session_valid_cmp)))
    else $error("session valid status does not follow comparator");

  chk_sess_end_rise: assert property (
    (int_rise_en[CH_SE] && !session_end_cmp ##1 int_rise_en[CH_SE] && session_end_cmp)
      |=> session_end_sts)
    else $error("session end status missed rising comparator");

  chk_sess_end_off: assert property (
    !(int_rise_en[CH_SE] | int_fall_en[CH_SE]) |=> !session_end_sts)
    else $error("disabled session end reads one");

  chk_sess_valid_cmd: assert property (
    $changed(session_valid_sts) |=> rx_cmd_req_q && (rx_sess_valid_q == $past(session_valid_sts)))
    else $error("no status command on session valid change");

  chk_sess_valid_alive: assert property (
    !(int_rise_en[CH_SV] | int_fall_en[CH_SV]) |=> (session_valid_sts == $past(session_valid_cmp)))
    else $error("session valid comparator stopped with enables clear");

  chk_sv_no_irq: assert property (
    (!int_rise_en[CH_SV] && !int_fall_en[CH_SV])[*2] |-> !irq_v[CH_SV])
    else $error("session valid interrupt while disabled");

  chk_bus_valid_off: assert property (
    !(int_rise_en[CH_BV] | int_fall_en[CH_BV]) |=> !bus_valid_sts)
    else $error("disabled bus valid reads one");

  chk_ext_decode: assert property (
    (ext_sel_q && ind_pass_thru)[*2] |=> rx_bus_valid_q == ($past(ind_complement) ? 1'b0 : 1'b1))
    else $error("pass-through encoding wrong");

  chk_ext_reset_off: assert property (
    $rose(rst_n) |-> !ext_sel_q)
    else $error("external indicator logic on after reset");

  chk_supply_or: assert property (
    (supply_drive_req | ext_supply_drive_req) |=> supply_switch_en)
    else $error("supply switch not asserted");

  chk_supply_off: assert property (
    !(supply_drive_req | ext_supply_drive_req) |=> !supply_switch_en)
    else $error("supply switch asserted without drive bit");

  chk_serial_level: assert property (
    serial_mode |=> (reg_level_q == $past(serial_mode_reg_level)) && !line_state_shown_q)
    else $error("serial mode effects missing");

  chk_vdat_se0: assert property (
    (line_state != LS_SE0) |=> !data_voltage_detect_sts)
    else $error("data voltage detect outside SE0");

  chk_pullup_reset: assert property (
    !chip_reset_n |=> !plus_weak_pullup_q && !minus_weak_pullup_q)
    else $error("weak pull-up on during chip reset");

  chk_irq_rise: assert property (
    $rose(sts_v[CH_VD]) && $past(int_rise_en[CH_VD]) |-> ##1 int_event_q)
    else $error("rising edge did not interrupt");

  cov_sess_valid_cmd: cover property ($rose(session_valid_sts) ##1 rx_cmd_req_q);
  cov_supply_on:      cover property ($rose(supply_switch_en));
  cov_vdat_irq:       cover property ($rose(data_voltage_detect_sts) ##1 int_source_q[CH_VD]);
  cov_serial_mode:    cover property ($rose(serial_mode) ##1 !line_state_shown_q);
endmodule

/* test/link_model.sv */
// behavioural link controller that programs the charger-detect controls
module link_model (
  // requested charger mode and product role
  input  wire logic [2:0] mode,
  input  wire logic       otg_role,
  // charger-detect controls towards the device
  output logic            data_volt_source_en,
  output logic            data_current_sink_en,
  output logic            contact_detect_en,
  output logic            host_charger_en,
  output logic            plus_line_pulldown,
  output logic            minus_line_pulldown,
  // session end enable for both edge registers
  output logic            sess_end_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ctl; // source, sink, contact, host, plus pd, minus pd
  always_comb begin
    case (mode)
      3'h1:    ctl = 6'h09; // connect detect: contact detect and minus pulldown
      3'h2:    ctl = 6'h30; // charger detection: source and sink only
      3'h3:    ctl = 6'h17; // host port idle: sink, host charger, both pulldowns
      3'h4:    ctl = 6'h37; // host port with charging device: source added
      3'h5:    ctl = 6'h07; // host port traffic: source and sink cleared
      default: ctl = 6'h00; // device traffic: everything off
    endcase
  end
  assign {data_volt_source_en, data_current_sink_en, contact_detect_en} = ctl[5:3];
  assign {host_charger_en, plus_line_pulldown, minus_line_pulldown} = ctl[2:0];
  // session end kept only in otg products
  assign sess_end_en = otg_role;
endmodule

/* test/otg_vbus_monitor_control_test.sv */
// self-checking bench for the bus monitor and charger control block
module otg_vbus_monitor_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import otg_mon_pkg::*;
  // clock, resets and comparator levels
  logic       sys_clk = 1'h0, rst_n = 1'h0, chip_reset_n = 1'h0;
  logic       bus_valid_cmp = 1'h0, session_valid_cmp = 1'h0, session_end_cmp = 1'h0, data_voltage_detect = 1'h0;
  logic [1:0] line_state = 2'h1, serial_mode_reg_level = 2'h0;
  logic [3:0] rise_q = 4'h0, fall_q = 4'h0;
  wire  [3:0] int_rise_en, int_fall_en;
  // control levels; supply requests start high to show reset wins
  logic       use_ext_valid_ind = 1'h0, ind_pass_thru = 1'h0, ind_complement = 1'h0;
  logic       power_rail_discharge = 1'h0, power_rail_charge = 1'h0;
  logic       supply_drive_req = 1'h1, ext_supply_drive_req = 1'h1;
  logic       serial_mode = 1'h0, suspend_n = 1'h1, plus_weak_pullup_req = 1'h1, minus_weak_pullup_req = 1'h1;
  logic [2:0] mode = 3'h0;
  logic       otg_role = 1'h1;
  wire        data_volt_source_en, data_current_sink_en, contact_detect_en, host_charger_en;
  wire        plus_line_pulldown, minus_line_pulldown, sess_end_en;
  // design outputs
  logic       bus_valid_sts, session_valid_sts, session_end_sts, data_voltage_detect_sts, int_event_q;
  logic       rx_cmd_req_q, rx_bus_valid_q, rx_sess_valid_q, rx_sess_end_q, discharge_en_q, charge_en_q;
  logic [3:0] int_source_q;
  logic [1:0] reg_level_q, pin_line_state_q;
  logic       supply_switch_en, line_state_shown_q, volt_source_on_q, current_sink_on_q, contact_detect_on_q;
  logic       host_charger_on_q, plus_pulldown_on_q, minus_pulldown_on_q, plus_weak_pullup_q, minus_weak_pullup_q;
  int         err_total = 0, checks = 0, cycles = 0;

  // the link drops the session end enable from both edge registers
  assign int_rise_en = {rise_q[3], rise_q[2] & sess_end_en, rise_q[1:0]};
  assign int_fall_en = {fall_q[3], fall_q[2] & sess_end_en, fall_q[1:0]};

  otg_vbus_monitor_control otg_vbus_monitor_control_i (
    .sys_clk, .rst_n, .chip_reset_n, .bus_valid_cmp, .session_valid_cmp, .session_end_cmp, .data_voltage_detect,
    .line_state, .int_rise_en, .int_fall_en, .use_ext_valid_ind, .ind_pass_thru, .ind_complement,
    .power_rail_discharge, .power_rail_charge, .supply_drive_req, .ext_supply_drive_req, .serial_mode,
    .serial_mode_reg_level, .suspend_n, .data_volt_source_en, .data_current_sink_en, .contact_detect_en,
    .host_charger_en, .plus_line_pulldown, .minus_line_pulldown, .plus_weak_pullup_req, .minus_weak_pullup_req,
    .bus_valid_sts, .session_valid_sts, .session_end_sts, .data_voltage_detect_sts, .rx_cmd_req_q,
    .rx_bus_valid_q, .rx_sess_valid_q, .rx_sess_end_q, .int_event_q, .int_source_q, .discharge_en_q,
    .charge_en_q, .supply_switch_en, .reg_level_q, .pin_line_state_q, .line_state_shown_q, .volt_source_on_q,
    .current_sink_on_q, .contact_detect_on_q, .host_charger_on_q, .plus_pulldown_on_q, .minus_pulldown_on_q,
    .plus_weak_pullup_q, .minus_weak_pullup_q);

  link_model link_model_i (
    .mode, .otg_role, .data_volt_source_en, .data_current_sink_en, .contact_detect_en, .host_charger_en,
    .plus_line_pulldown, .minus_line_pulldown, .sess_end_en);

  // free-running clock and hang guard; the run needs about 160 cycles
  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end

  // compare and count; values are widened to one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // let n edges land, then sample where outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // bus valid field source: k = {internal, use_ext, pass_thru, complement}
  function automatic logic bv_exp(input logic [3:0] k);
    if (!k[2]) return k[3];
    if (k[1]) return EXT_IND_LEVEL ^ k[0];
    return k[0] ? 1'h0 : k[3];
  endfunction

  // weak pull-ups held off by the chip reset pin, also mid-run
  task automatic t_pullups();
    chk({plus_weak_pullup_q, minus_weak_pullup_q}, 2'h0);
    @(posedge sys_clk);
    chip_reset_n <= 1'h1;
    tick(1);
    chk({plus_weak_pullup_q, minus_weak_pullup_q}, 2'h3);
    @(posedge sys_clk);
    chip_reset_n <= 1'h0;
    tick(1);
    chk({plus_weak_pullup_q, minus_weak_pullup_q}, 2'h0);
    @(posedge sys_clk);
    chip_reset_n <= 1'h1;
  endtask

  // every pair of drive bits and pulsing bits
  task automatic t_supply();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {supply_drive_req, ext_supply_drive_req} <= i[1:0];
      {power_rail_charge, power_rail_discharge} <= i[1:0];
      tick(1);
      chk(supply_switch_en, |i[1:0]);
      chk(discharge_en_q, i[0]);
      chk(charge_en_q, i[1]);
    end
  endtask

  // session end reads 1 when enabled, 0 once the link drops its enables
  task automatic t_sess_end();
    @(posedge sys_clk);
    {rise_q, fall_q} <= 8'h44;
    session_end_cmp <= 1'h1;
    tick(1);
    chk(session_end_sts, 1'h1);
    tick(1);
    chk({rx_cmd_req_q, rx_sess_end_q}, 2'h3);
    @(posedge sys_clk);
    otg_role <= 1'h0;
    tick(1);
    chk(session_end_sts, 1'h0);
    @(posedge sys_clk);
    otg_role <= 1'h1;
    session_end_cmp <= 1'h0;
    {rise_q, fall_q} <= 8'h00;
  endtask

  // session valid with both enables clear: commands yes, interrupts no
  task automatic t_sess_valid();
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk);
      session_valid_cmp <= v[0];
      tick(1);
      chk(session_valid_sts, v[0]);
      tick(1);
      chk(rx_cmd_req_q, 1'h1);
      chk(rx_sess_valid_q, v[0]);
      chk(int_event_q, 1'h0);
    end
  endtask

  // rising then falling interrupt on session end, then no interrupt on a rise with only the fall enable set
  task automatic t_edges();
    @(posedge sys_clk);
    rise_q <= 4'h4;
    @(posedge sys_clk);
    session_end_cmp <= 1'h1;
    tick(2);
    chk({int_event_q, int_source_q}, 8'h14);
    tick(1);
    chk(int_event_q, 1'h0);
    @(posedge sys_clk);
    {rise_q, fall_q} <= 8'h04;
    @(posedge sys_clk);
    session_end_cmp <= 1'h0;
    tick(2);
    chk({int_event_q, int_source_q}, 8'h14);
    @(posedge sys_clk);
    session_end_cmp <= 1'h1;
    tick(2);
    chk(int_event_q, 1'h0);
    @(posedge sys_clk);
    session_end_cmp <= 1'h0;
    fall_q <= 4'h0;
  endtask

  // data voltage detect qualified by SE0, reported while suspended
  task automatic t_vdet();
    @(posedge sys_clk);
    suspend_n <= 1'h0;
    rise_q <= 4'h8;
    data_voltage_detect <= 1'h1;
    tick(2);
    chk({data_voltage_detect_sts, int_event_q}, 2'h0);
    @(posedge sys_clk);
    line_state <= LS_SE0;
    tick(1);
    chk(data_voltage_detect_sts, 1'h1);
    tick(1);
    chk({int_event_q, int_source_q}, 8'h18);
    @(posedge sys_clk);
    {suspend_n, data_voltage_detect, rise_q, line_state} <= 8'h81;
  endtask

  // bus valid status gating and the whole indicator decode table
  task automatic t_bus_valid();
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      bus_valid_cmp <= 1'h1;
      rise_q <= {3'h0, i[3]};
      {use_ext_valid_ind, ind_pass_thru, ind_complement} <= i[2:0];
      tick(4);
      chk(bus_valid_sts, i[3]);
      chk(rx_bus_valid_q, bv_exp(i[3:0]));
    end
    @(posedge sys_clk);
    // external logic off: the comparator wins over a pass-through setting that would force zero
    {bus_valid_cmp, use_ext_valid_ind, ind_pass_thru, ind_complement, rise_q} <= 8'hb1;
    tick(4);
    chk(rx_bus_valid_q, 1'h1);
  endtask

  // serial mode selects the regulator level and hides line state
  task automatic t_serial();
    @(posedge sys_clk);
    {line_state, serial_mode_reg_level, serial_mode} <= 5'h0f;
    tick(1);
    chk({reg_level_q, pin_line_state_q, line_state_shown_q}, 5'h18);
    @(posedge sys_clk);
    serial_mode <= 1'h0;
    tick(1);
    chk({reg_level_q, pin_line_state_q, line_state_shown_q}, {REG_LEVEL_NORMAL, 2'h1, 1'h1});
  endtask

  // each link charger mode reaches the analog controls in low power
  task automatic t_charger();
    for (int m = 0; m < 6; m++) begin
      @(posedge sys_clk);
      suspend_n <= 1'h0;
      mode <= m[2:0];
      tick(1);
      chk({volt_source_on_q, current_sink_on_q, contact_detect_on_q, host_charger_on_q, plus_pulldown_on_q,
           minus_pulldown_on_q}, {data_volt_source_en, data_current_sink_en, contact_detect_en,
           host_charger_en, plus_line_pulldown, minus_line_pulldown});
    end
  endtask

  // counts, verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reset for 16 cycles, then each scenario in turn
  initial begin
    tick(15);
    chk(supply_switch_en, 1'h0);
    @(posedge sys_clk);
    {rst_n, supply_drive_req, ext_supply_drive_req} <= 3'h4;
    tick(1);
    t_pullups();
    t_supply();
    t_sess_end();
    t_sess_valid();
    t_edges();
    t_vdet();
    t_bus_valid();
    t_serial();
    t_charger();
    results();
  end
endmodule
